// [verilog/cpg_defines.svh]
// Constants for the calibration pulse generator.
// Assumes inclusion by the package and the top module.
`ifndef CPG_DEFINES_SVH
`define CPG_DEFINES_SVH
// Sizes
`define CPG_NCH      128
`define CPG_WID_W    8
`define CPG_AMP_W    6
`define CPG_DLY_W    5
`define CPG_CNT_W    16
`define CPG_AW       8
// Register byte offsets
`define CPG_A_CTRL   8'h00
`define CPG_A_AMP    8'h04
`define CPG_A_DLY    8'h08
`define CPG_A_STAT   8'h0c
`define CPG_A_MASK0  8'h10
`define CPG_A_MASK3  8'h1c
// Field positions
`define CPG_F_INV    8
// Reset values
`define CPG_R_WID    8'h04
`define CPG_R_AMP    6'h0e
`define CPG_R_DLY    5'h00
// Bus responses
`define CPG_OKAY     2'h0
`define CPG_SLVERR   2'h2
`endif

// [verilog/cpg_pkg.sv]
// Types for the calibration pulse generator.
// Assumes cpg_defines.svh is on the include path.
`include "cpg_defines.svh"
package cpg_pkg;
	// Whole state of the block, one register bank
	typedef struct packed {
		logic                   s1;     // Sync stage one
		logic                   s2;     // Sync stage two
		logic                   s3;     // Edge history
		logic [`CPG_WID_W-1:0]  cnt;    // Stretcher count
		logic [`CPG_WID_W-1:0]  wid;    // Width setting
		logic                   inv;    // Polarity setting
		logic [`CPG_AMP_W-1:0]  amp;    // Amplitude code
		logic [`CPG_DLY_W-1:0]  dly;    // Clock delay code
		logic [`CPG_NCH-1:0]    mask;   // Channel enables
		logic [`CPG_NCH-1:0]    mask_s; // Mask held for pulse
		logic                   inv_s;  // Polarity held
		logic [`CPG_NCH-1:0]    inj;    // Channel steps
		logic [`CPG_CNT_W-1:0]  nfire;  // Injection count
		logic                   awrdy;
		logic                   wrdy;
		logic                   bvld;
		logic [1:0]             bresp;
		logic                   arrdy;
		logic                   rvld;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic                   awh;    // Address held
		logic [`CPG_AW-1:0]     awa;
		logic                   wh;     // Data held
		logic [31:0]            wd;
		logic [3:0]             ws;
	} cpg_state_t;
endpackage : cpg_pkg

// [verilog/cpg_top.sv]
// Calibration pulse generator: trigger sync, stretcher,
// polarity, channel mask, amplitude and delay codes.
// Assumes an AXI4-Lite master; a trigger of any length gives one start.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cpg_defines.svh"

module cpg_top (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  calib_cmd,
	output logic [`CPG_NCH-1:0]        inj_step,
	output logic [`CPG_AMP_W-1:0]      cal_amp,
	output logic [`CPG_DLY_W-1:0]      cal_dly,
	input  wire logic [`CPG_AW-1:0]    s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`CPG_AW-1:0]    s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	// Byte lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Width zero would give no pulse; treat it as one
	function automatic logic [`CPG_WID_W-1:0] eff_wid(
		input logic [`CPG_WID_W-1:0] w);
		return (w == '0) ? `CPG_WID_W'(1) : w;
	endfunction : eff_wid

	cpg_pkg::cpg_state_t q, d;   // Current and next state
	logic                 start; // One start per command
	logic                 wfire; // Write performed
	logic [`CPG_AW-1:0]   wa;    // Effective write address
	logic [31:0]          wdv;   // Effective write data
	logic [3:0]           wsv;   // Effective strobes
	logic [1:0]           mi;    // Mask word index
	logic [31:0]          old;   // Word before the write

	// Next-state logic, one process for the whole block
	always_comb begin
		d     = q;
		// Sync chain; stage one feeds only stage two
		d.s1  = calib_cmd;
		d.s2  = q.s1;
		d.s3  = q.s2;
		start = q.s2 && !q.s3;

		// Stretcher; a retrigger mid-pulse is ignored
		if (q.cnt != '0) begin
			d.cnt = q.cnt - `CPG_WID_W'(1);
		end else if (start) begin
			d.cnt    = eff_wid(q.wid);
			d.mask_s = q.mask;
			d.inv_s  = q.inv;
			d.nfire  = q.nfire + `CPG_CNT_W'(1);
		end else begin
			// Idle: follow settings so rest level is current
			d.mask_s = q.mask;
			d.inv_s  = q.inv;
		end
		// Gate and polarity; disabled channels stay low
		d.inj = d.mask_s & {`CPG_NCH{(d.cnt != '0) ^ d.inv_s}};

		// Write channels may arrive in either order
		if (s_axi_awvalid && q.awrdy) begin
			d.awh   = 1'b1;
			d.awa   = s_axi_awaddr;
			d.awrdy = 1'b0;
		end
		if (s_axi_wvalid && q.wrdy) begin
			d.wh   = 1'b1;
			d.wd   = s_axi_wdata;
			d.ws   = s_axi_wstrb;
			d.wrdy = 1'b0;
		end
		wa    = q.awh ? q.awa : s_axi_awaddr;
		wdv   = q.wh ? q.wd : s_axi_wdata;
		wsv   = q.wh ? q.ws : s_axi_wstrb;
		wfire = (q.awh || (s_axi_awvalid && q.awrdy)) &&
			(q.wh || (s_axi_wvalid && q.wrdy)) && !q.bvld;
		mi    = wa[3:2];
		old   = q.mask[mi*32 +: 32];
		if (wfire) begin
			d.awh   = 1'b0;
			d.wh    = 1'b0;
			d.bvld  = 1'b1;
			d.bresp = `CPG_OKAY;
			d.awrdy = 1'b0;
			d.wrdy  = 1'b0;
			unique case (wa[`CPG_AW-1:2])
				`CPG_A_CTRL >> 2: begin
					d.wid = wsv[0] ? wdv[`CPG_WID_W-1:0] : q.wid;
					d.inv = wsv[1] ? wdv[`CPG_F_INV] : q.inv;
				end
				`CPG_A_AMP >> 2: begin
					d.amp = wsv[0] ? wdv[`CPG_AMP_W-1:0] : q.amp;
				end
				`CPG_A_DLY >> 2: begin
					d.dly = wsv[0] ? wdv[`CPG_DLY_W-1:0] : q.dly;
				end
				`CPG_A_STAT >> 2: begin
					// Status is read only; write ignored
				end
				default: begin
					if (wa >= `CPG_A_MASK0 && wa <= `CPG_A_MASK3) begin
						d.mask[mi*32 +: 32] = merge(old, wdv, wsv);
					end else begin
						d.bresp = `CPG_SLVERR;
					end
				end
			endcase
		end
		// Response held until the master takes it
		if (q.bvld && s_axi_bready) begin
			d.bvld  = 1'b0;
			d.awrdy = 1'b1;
			d.wrdy  = 1'b1;
		end

		// Read: one outstanding, answer next cycle
		if (s_axi_arvalid && q.arrdy) begin
			d.arrdy = 1'b0;
			d.rvld  = 1'b1;
			d.rresp = `CPG_OKAY;
			d.rdata = '0;
			unique case (s_axi_araddr[`CPG_AW-1:2])
				`CPG_A_CTRL >> 2: begin
					d.rdata[`CPG_WID_W-1:0] = q.wid;
					d.rdata[`CPG_F_INV]     = q.inv;
				end
				`CPG_A_AMP >> 2: begin
					d.rdata[`CPG_AMP_W-1:0] = q.amp;
				end
				`CPG_A_DLY >> 2: begin
					d.rdata[`CPG_DLY_W-1:0] = q.dly;
				end
				`CPG_A_STAT >> 2: begin
					// Busy at bit 16, injection count below
					d.rdata[`CPG_CNT_W-1:0] = q.nfire;
					d.rdata[`CPG_CNT_W]     = (q.cnt != '0);
				end
				default: begin
					if (s_axi_araddr >= `CPG_A_MASK0 &&
						s_axi_araddr <= `CPG_A_MASK3) begin
						d.rdata = q.mask[s_axi_araddr[3:2]*32 +: 32];
					end else begin
						d.rresp = `CPG_SLVERR;
					end
				end
			endcase
		end
		if (q.rvld && s_axi_rready) begin
			d.rvld  = 1'b0;
			d.arrdy = 1'b1;
		end
	end

	// State register; synchronous reset
	always_ff @(posedge clk) begin
		if (srst) begin
			q       <= '0;
			q.wid   <= `CPG_R_WID;
			q.amp   <= `CPG_R_AMP;
			q.dly   <= `CPG_R_DLY;
			q.awrdy <= 1'b1;
			q.wrdy  <= 1'b1;
			q.arrdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign inj_step      = q.inj;
	assign cal_amp       = q.amp;
	assign cal_dly       = q.dly;
	assign s_axi_awready = q.awrdy;
	assign s_axi_wready  = q.wrdy;
	assign s_axi_bvalid  = q.bvld;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arrdy;
	assign s_axi_rvalid  = q.rvld;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rdata   = q.rdata;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence seq_cmd;
		q.s1 && !q.s2 && q.s3 == q.s2;
	endsequence
	sequence seq_start;
		q.s2 && !q.s3 && q.cnt == '0;
	endsequence

	a_sync_path: assert property (seq_cmd ##1 seq_start |=>
		q.cnt == eff_wid($past(q.wid))) else $error("start not loaded");
	a_edge_once: assert property ($rose(q.s2) |=> ##1
		!(q.s2 && !q.s3)) else $error("double start");
	a_no_spur: assert property ($past(q.cnt) == '0 && q.cnt != '0
		|-> $past(q.s2 && !q.s3)) else $error("spurious pulse");
	a_width_dec: assert property (q.cnt > 1 |=>
		q.cnt == $past(q.cnt) - `CPG_WID_W'(1)) else $error("bad stretch");
	a_pol_out: assert property (q.cnt != '0 |=> $past(q.cnt) == 1 ||
		inj_step == (q.mask_s & {`CPG_NCH{~q.inv_s}})) else $error("bad polarity");
	a_mask_gate: assert property ((inj_step & ~q.mask_s) == '0)
		else $error("disabled channel stepped");
	a_amp_wr: assert property (wfire && wa == `CPG_A_AMP && wsv[0]
		|=> cal_amp == $past(wdv[`CPG_AMP_W-1:0])) else $error("amp not taken");
	a_dly_wr: assert property (wfire && wa == `CPG_A_DLY && wsv[0]
		|=> cal_dly == $past(wdv[`CPG_DLY_W-1:0])) else $error("delay not taken");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule : cpg_top

// [verif/cpg_partner.sv]
// Far-side model: fast-control command source.
// Assumes the bench calls send_cmd right after a rising edge.
`timescale 1ns/100ps
module cpg_partner (
	input  wire logic clk,       // Main clock
	output logic      calib_cmd  // Decoded calibrate command
);
	// Line idles low outside commands
	initial calib_cmd = 1'h0;

	// Command held for hold edges; long holds model a slow decoder
	task automatic send_cmd(input int hold);
		calib_cmd <= 1'h1;
		repeat (hold) @(posedge clk);
		calib_cmd <= 1'h0;
	endtask : send_cmd
endmodule : cpg_partner

// [verif/cpg_top_tb.sv]
// Bench for the pulse generator: registers, trigger, shaping, masks.
// Assumes cpg_top and cpg_partner are compiled before it.
`timescale 1ns/100ps
`include "cpg_defines.svh"
module cpg_top_tb;
	logic         clk = 1'h0, srst = 1'h1;          // Clock and reset
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00;   // Bus addresses
	logic [31:0]  wdata = 32'h0, rdata, rd_data;    // Bus data
	logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic         arvalid = 1'h0, rready = 1'h0;
	logic         awready, wready, bvalid, arready, rvalid, calib_cmd;
	logic [1:0]   bresp, rresp, rd_resp, wr_resp;
	logic [127:0] inj_step, mask;                   // Steps and expected mask
	logic [5:0]   cal_amp;
	logic [4:0]   cal_dly;
	logic [31:0]  rnd = 32'h20;                     // LFSR state, fixed seed
	int           fail_count = 0, samples_checked = 0, fired = 0;

	// 100 ns period
	always #50 clk = ~clk;

	cpg_partner i_cpg_partner (.clk(clk), .calib_cmd(calib_cmd));
	cpg_top i_cpg_top (.clk(clk), .srst(srst), .calib_cmd(calib_cmd), .inj_step(inj_step),
		.cal_amp(cal_amp), .cal_dly(cal_dly), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// Next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Step level: enabled channels show busy xor invert
	function automatic logic [127:0] exp_inj(input logic [127:0] m, input logic iv, input logic busy);
		return (busy ^ iv) ? m : 128'h0;
	endfunction : exp_inj

	// One comparison, counted
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk

	// Write: both channels offered together, each released when taken
	// Handshakes judged on settled values before the edge, not in the edge's race
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			#1;
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			wr_resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end while (!tb);
		bready <= 1'h0;
	endtask : wr

	// Read: data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			#1;
			ta = arvalid && arready;
			tr = rvalid && rready;
			rd_data = rdata;
			rd_resp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'h0;
		end while (!tr);
		rready <= 1'h0;
	endtask : rd

	// One injection: random mask, given width and polarity
	task automatic pulse(input logic [7:0] w, input logic iv);
		int n;
		n = 0;
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			mask[32*k +: 32] = rnd | 32'h1; // Never empty, else levels alias
			wr(8'h10 + 8'(4 * k), mask[32*k +: 32]);
		end
		wr(8'h00, {23'h0, iv, w});
		#1 chk(inj_step, exp_inj(mask, iv, 1'h0));
		@(posedge clk);
		i_cpg_partner.send_cmd(1);
		@(posedge clk);
		#1 chk(inj_step, exp_inj(mask, iv, 1'h0));
		repeat (300) begin
			@(posedge clk);
			#1;
			if (inj_step !== exp_inj(mask, iv, 1'h1)) break;
			n++;
		end
		chk(128'(n), 128'((w == 8'h0) ? 8'h1 : w));
		chk(inj_step, exp_inj(mask, iv, 1'h0));
		fired++;
	endtask : pulse

	// Summary then verdict; the single end of the run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// Hang guard, far beyond the planned run
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		logic [7:0] widths [6];
		widths = '{8'h00, 8'h01, 8'hff, 8'h03, 8'h00, 8'h00};
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		#1 chk(cal_amp, 6'h0e);
		chk(cal_dly, 5'h00);
		chk(inj_step, 128'h0);
		rd(8'h00);
		chk(rd_data, 32'h4);
		rnd = lfsr(rnd);
		wr(8'h04, rnd);
		chk(cal_amp, rnd[5:0]);
		chk(wr_resp, 2'h0);
		wr(8'h08, 32'hff);
		chk(cal_dly, 5'h1f);
		rd(8'h40);
		chk(rd_resp, 2'h2);
		wr(8'h40, 32'h0);
		chk(wr_resp, 2'h2);
		// Corner widths, then random ones; both polarities
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			pulse((i > 3) ? {3'h0, rnd[4:0]} : widths[i], i[0]);
		end
		// Long level command: one start only
		wr(8'h00, 32'h2);
		@(posedge clk);
		i_cpg_partner.send_cmd(12);
		fired++;
		repeat (10) @(posedge clk);
		rd(8'h0c);
		chk(rd_data[16:0], {1'h0, 16'(fired)});
		print_verdict();
	end
endmodule : cpg_top_tb
